// ### rtl/remote_sensor_los_supervisor.sv
`timescale 1ns/1ps
module remote_sensor_los_supervisor #(
    parameter int LOS_CYCLES = los_pkg::LOS_CYCLES_DFLT
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [los_pkg::ADDR_W-1:0] addr,
    input wire logic [los_pkg::DATA_W-1:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [los_pkg::DATA_W-1:0] rd_data,
    input wire logic frame_valid,
    input wire los_pkg::fkind_e frame_kind,
    input wire logic [los_pkg::ID_W-1:0] frame_id,
    input wire logic [los_pkg::FRAME_W-1:0] frame_data,
    input wire logic forward_limit_input,
    input wire logic reverse_limit_input,
    input wire logic [los_pkg::DUTY_W-1:0] target_duty,
    input wire logic [los_pkg::DATA_W-1:0] local_pos,
    input wire logic [los_pkg::DATA_W-1:0] local_vel,
    output logic [los_pkg::DUTY_W-1:0] motor_duty_out,
    output logic fwd_limit_active,
    output logic rev_limit_active,
    output logic signal_loss_fault,
    output logic limit_fault,
    output logic [los_pkg::DATA_W-1:0] sel_pos,
    output logic [los_pkg::DATA_W-1:0] sel_vel,
    output logic irq
);
    import los_pkg::*;

    localparam int CNT_W = $clog2(LOS_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(LOS_CYCLES - 1);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic inhibit;
        lim_type_e lim_type;
        logic [ID_W-1:0] lim_id;
        logic [NUM_FILT-1:0][3:0] filt_src;
        logic [NUM_FILT-1:0][ID_W-1:0] filt_id;
        fb_e fb_choice;
        logic [ST_W-1:0] status;
        logic [ST_W-1:0] mask;
        logic [NUM_SRC-1:0][CNT_W-1:0] tmr;
        logic [NUM_SRC-1:0] lost;
        logic fwd;
        logic rev;
        logic [DUTY_W-1:0] duty;
        logic los_fault;
        logic lim_fault;
        logic irq;
        logic [DATA_W-1:0] rd_data;
        logic rd_mem;
        logic rd_hi;
        logic [DATA_W-1:0] sel_pos;
        logic [DATA_W-1:0] sel_vel;
    } sup_s;

    sup_s q_ff;
    sup_s nxt_q;
    dec_s [NUM_FILT-1:0] dec;
    logic [NUM_SRC-1:0] src_active;
    logic [NUM_SRC-1:0] src_hit;
    logic lim_remote;
    logic lim_hit;
    logic force_neutral;
    logic [ST_W-1:0] ev;
    store_if st ();

    // ************************************************************
    // frame decoding
    // ************************************************************
    function automatic logic [DATA_W-1:0] sext_axis(
        input logic [FRAME_W-1:0] data,
        input int lsb
    );
        logic [AXIS_W-1:0] f;
        f = data[lsb +: AXIS_W];
        return {{(DATA_W - AXIS_W){f[AXIS_W-1]}}, f};
    endfunction

    function automatic dec_s decode(
        input logic [3:0] src,
        input logic [ID_W-1:0] id,
        input logic valid,
        input fkind_e kind,
        input logic [ID_W-1:0] fid,
        input logic [FRAME_W-1:0] data
    );
        dec_s d;
        d = '0;
        d.pos = data[DATA_W-1:0];
        d.vel = data[VEL_LSB +: DATA_W];
        case (src)
            SRC_CTRL_SENSOR: begin
                d.hit = (kind == FK_CTRL_STAT);
                d.has_vel = 1'b1;
            end
            SRC_IMU_YAW, SRC_IMU_PITCH, SRC_IMU_ROLL: begin
                d.hit = (kind == FK_IMU);
                d.pos = sext_axis(data, AXIS_W * int'(src - SRC_IMU_YAW));
            end
            SRC_CIMU_YAW, SRC_CIMU_PITCH, SRC_CIMU_ROLL: begin
                d.hit = (kind == FK_CTRL_IMU);
                d.pos = sext_axis(data, AXIS_W * int'(src - SRC_CIMU_YAW));
            end
            SRC_IO_QUAD: begin
                d.hit = (kind == FK_IO_QUAD);
                d.has_vel = 1'b1;
            end
            SRC_IO_PWM0, SRC_IO_PWM1, SRC_IO_PWM2, SRC_IO_PWM3: begin
                d.hit = (kind == FK_IO_PWM);
                d.pos = sext_axis(data, AXIS_W * int'(src - SRC_IO_PWM0));
            end
            default: begin
                d.hit = 1'b0;
            end
        endcase
        d.hit = d.hit && valid && (fid == id);
        return d;
    endfunction

    generate
        for (genvar g = 0; g < NUM_FILT; g++) begin : g_filt
            assign dec[g] = decode(q_ff.filt_src[g], q_ff.filt_id[g],
                frame_valid, frame_kind, frame_id, frame_data);
            assign src_active[g+1] = (q_ff.filt_src[g] != SRC_OFF);
            assign src_hit[g+1] = dec[g].hit;
            assign st.wr_en[g] = dec[g].hit;
            assign st.wr_vel_en[g] = dec[g].hit && dec[g].has_vel;
            assign st.wr_pos[g] = dec[g].pos;
            assign st.wr_vel[g] = dec[g].vel;
        end
    endgenerate

    assign lim_remote = (q_ff.lim_type != LIM_LOCAL);
    assign lim_hit = frame_valid && (frame_id == q_ff.lim_id) &&
        ((q_ff.lim_type == LIM_REMOTE_CTRL && frame_kind == FK_CTRL_LIM) ||
         (q_ff.lim_type == LIM_REMOTE_IO && frame_kind == FK_IO_LIM));
    assign src_active[0] = lim_remote;
    assign src_hit[0] = lim_hit;
    assign force_neutral = lim_remote && q_ff.lost[0] && !q_ff.inhibit;

    // ************************************************************
    // value store: port a serves software reads, port b feedback
    // ************************************************************
    assign st.rd_a_idx = addr[VAL_IDX_BIT];
    assign st.rd_b_idx = IDX_W'(q_ff.fb_choice == FB_REMOTE1);

    filter_store u_store (
        .clk(clk),
        .rst_n(rst_n),
        .st(st)
    );

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        nxt_q = q_ff;
        // loss timers: index 0 is the limit source, then the filters
        for (int i = 0; i < NUM_SRC; i++) begin
            if (!src_active[i] || src_hit[i]) begin
                nxt_q.tmr[i] = '0;
                nxt_q.lost[i] = 1'b0;
            end else if (!q_ff.lost[i]) begin
                if (q_ff.tmr[i] == CNT_LAST) begin
                    nxt_q.lost[i] = 1'b1;
                end else begin
                    nxt_q.tmr[i] = q_ff.tmr[i] + 1'b1;
                end
            end
        end
        // a lost remote limit source keeps its last reported pins
        if (!lim_remote) begin
            nxt_q.fwd = forward_limit_input;
            nxt_q.rev = reverse_limit_input;
        end else if (lim_hit) begin
            nxt_q.fwd = frame_data[LIM_FWD_BIT];
            nxt_q.rev = frame_data[LIM_REV_BIT];
        end
        nxt_q.duty = force_neutral ? '0 : target_duty;
        nxt_q.los_fault = |q_ff.lost;
        nxt_q.lim_fault = force_neutral && (target_duty != '0);
        if (q_ff.fb_choice == FB_LOCAL) begin
            nxt_q.sel_pos = local_pos;
            nxt_q.sel_vel = local_vel;
        end else begin
            nxt_q.sel_pos = st.rd_b_q[DATA_W-1:0];
            nxt_q.sel_vel = st.rd_b_q[VEL_LSB +: DATA_W];
        end
        // register writes
        ev = {nxt_q.lim_fault & ~q_ff.lim_fault, nxt_q.lost & ~q_ff.lost};
        if (wr_en) begin
            if (addr == REG_CTRL) begin
                nxt_q.inhibit = wr_data[CTRL_INHIBIT_BIT];
            end else if (addr == REG_LIM_SRC) begin
                nxt_q.lim_type = lim_type_e'(wr_data[1:0]);
                nxt_q.lim_id = wr_data[CFG_ID_LSB +: ID_W];
            end else if (addr == REG_FILT0 || addr == REG_FILT1) begin
                nxt_q.filt_src[addr[2]] = wr_data[3:0];
                nxt_q.filt_id[addr[2]] = wr_data[CFG_ID_LSB +: ID_W];
            end else if (addr == REG_FB_SEL) begin
                nxt_q.fb_choice = fb_e'(wr_data[1:0]);
            end else if (addr == REG_STATUS) begin
                nxt_q.status = q_ff.status & ~wr_data[ST_W-1:0];
            end else if (addr == REG_MASK) begin
                nxt_q.mask = wr_data[ST_W-1:0];
            end
        end
        // a new event wins over a clear in the same cycle
        nxt_q.status = nxt_q.status | ev;
        nxt_q.irq = |(nxt_q.status & nxt_q.mask);
        // register reads
        nxt_q.rd_data = '0;
        nxt_q.rd_mem = 1'b0;
        nxt_q.rd_hi = addr[VAL_HALF_BIT];
        if (rd_en) begin
            if (addr == REG_CTRL) begin
                nxt_q.rd_data[CTRL_INHIBIT_BIT] = q_ff.inhibit;
            end else if (addr == REG_LIM_SRC) begin
                nxt_q.rd_data[1:0] = q_ff.lim_type;
                nxt_q.rd_data[CFG_ID_LSB +: ID_W] = q_ff.lim_id;
            end else if (addr == REG_FILT0 || addr == REG_FILT1) begin
                nxt_q.rd_data[3:0] = q_ff.filt_src[addr[2]];
                nxt_q.rd_data[CFG_ID_LSB +: ID_W] = q_ff.filt_id[addr[2]];
            end else if (addr == REG_FB_SEL) begin
                nxt_q.rd_data[1:0] = q_ff.fb_choice;
            end else if (addr == REG_STATUS) begin
                nxt_q.rd_data[ST_W-1:0] = q_ff.status;
            end else if (addr == REG_MASK) begin
                nxt_q.rd_data[ST_W-1:0] = q_ff.mask;
            end else if (addr == REG_STATE) begin
                nxt_q.rd_data[7:0] = {q_ff.rev, q_ff.fwd, force_neutral,
                    q_ff.lim_fault, q_ff.los_fault, q_ff.lost};
            end else if (addr >= REG_VAL0_POS && addr <= REG_VAL1_VEL &&
                         addr[1:0] == 2'h0) begin
                nxt_q.rd_mem = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q_ff <= '0;
            q_ff.inhibit <= RST_INHIBIT;
            q_ff.lim_type <= LIM_LOCAL;
            q_ff.fb_choice <= FB_LOCAL;
            q_ff.mask <= RST_MASK;
        end else begin
            q_ff <= nxt_q;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    // value words come straight from the store's read register
    assign rd_data = !q_ff.rd_mem ? q_ff.rd_data :
        (q_ff.rd_hi ? st.rd_a_q[VEL_LSB +: DATA_W] : st.rd_a_q[DATA_W-1:0]);
    assign motor_duty_out = q_ff.duty;
    assign fwd_limit_active = q_ff.fwd;
    assign rev_limit_active = q_ff.rev;
    assign signal_loss_fault = q_ff.los_fault;
    assign limit_fault = q_ff.lim_fault;
    assign sel_pos = q_ff.sel_pos;
    assign sel_vel = q_ff.sel_vel;
    assign irq = q_ff.irq;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_neutral_force: assert property (
        force_neutral |=> motor_duty_out == '0)
        else $error("duty not neutral on remote limit loss");
    chk_inhibit_pass: assert property (
        lim_remote && q_ff.lost[0] && q_ff.inhibit
        |=> motor_duty_out == $past(target_duty))
        else $error("inhibit did not keep normal drive");
    chk_remote_limit: assert property (
        lim_hit |=> fwd_limit_active == $past(frame_data[LIM_FWD_BIT]) &&
        rev_limit_active == $past(frame_data[LIM_REV_BIT]))
        else $error("remote limit pins not taken");
    chk_lost_timeout: assert property (
        src_active[0] && !src_hit[0] && q_ff.tmr[0] == CNT_LAST
        |=> q_ff.lost[0])
        else $error("limit source loss not raised at timeout");
    chk_frame_restart: assert property (
        src_hit[1] |=> q_ff.tmr[1] == '0 && !q_ff.lost[1])
        else $error("frame did not restart filter timer");
    chk_off_quiet: assert property (
        !src_active[2] |=> !q_ff.lost[2] ##1 !q_ff.lost[2] || src_active[2])
        else $error("filter set to off reported loss");
    chk_loss_flag: assert property (
        q_ff.lost[1] |=> signal_loss_fault)
        else $error("loss fault flag missing");
    chk_limit_fault: assert property (
        limit_fault |-> $past(force_neutral) && $past(target_duty) != '0)
        else $error("limit fault without cause");
    chk_sticky_irq: assert property (
        $rose(q_ff.lost[0]) |-> q_ff.status[ST_LIM_LOSS] &&
        (irq == |(q_ff.status & q_ff.mask)))
        else $error("loss event not latched");
    chk_fb_remote: assert property (
        q_ff.fb_choice == FB_REMOTE0 && $stable(q_ff.fb_choice)
        |=> sel_pos == $past(st.rd_b_q[DATA_W-1:0]))
        else $error("remote feedback not followed");

    cov_neutral: cover property (force_neutral ##1 motor_duty_out == '0);
    cov_filt_loss: cover property ($rose(q_ff.lost[1]));
    cov_resume: cover property (q_ff.lost[0] ##1 src_hit[0]);
    cov_val_read: cover property (rd_en && addr == REG_VAL0_POS);
endmodule

// ### rtl/los_pkg.sv
package los_pkg;

    // ************************************************************
    // widths and timing
    // ************************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int FRAME_W = 64;
    localparam int NUM_FILT = 2;
    localparam int NUM_SRC = NUM_FILT + 1;
    localparam int IDX_W = 1;
    localparam int ID_W = 6;
    localparam int DUTY_W = 16;
    localparam int LOS_TIME_MS = 100;
    localparam int CLK_FREQ_KHZ = 200000;
    localparam int LOS_CYCLES_DFLT = LOS_TIME_MS * CLK_FREQ_KHZ;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_LIM_SRC = 8'h04;
    localparam logic [ADDR_W-1:0] REG_FILT0 = 8'h08;
    localparam logic [ADDR_W-1:0] REG_FILT1 = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_FB_SEL = 8'h10;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h14;
    localparam logic [ADDR_W-1:0] REG_MASK = 8'h18;
    localparam logic [ADDR_W-1:0] REG_STATE = 8'h1c;
    localparam logic [ADDR_W-1:0] REG_VAL0_POS = 8'h20;
    localparam logic [ADDR_W-1:0] REG_VAL1_VEL = 8'h2c;
    localparam int VAL_HALF_BIT = 2;
    localparam int VAL_IDX_BIT = 3;

    // ************************************************************
    // field positions and reset values
    // ************************************************************
    localparam int CTRL_INHIBIT_BIT = 0;
    localparam int CFG_ID_LSB = 8;
    localparam int ST_LIM_LOSS = 0;
    localparam int ST_LIM_FAULT = 3;
    localparam int ST_W = 4;
    localparam int VEL_LSB = 32;
    localparam int AXIS_W = 16;
    localparam int LIM_FWD_BIT = 0;
    localparam int LIM_REV_BIT = 1;
    localparam logic RST_INHIBIT = 1'b0;
    localparam logic [ST_W-1:0] RST_MASK = 4'h0;

    // ************************************************************
    // enumerations
    // ************************************************************
    typedef enum logic [1:0] {
        LIM_LOCAL = 2'b00,
        LIM_REMOTE_CTRL = 2'b01,
        LIM_REMOTE_IO = 2'b10
    } lim_type_e;

    typedef enum logic [1:0] {
        FB_LOCAL = 2'b00,
        FB_REMOTE0 = 2'b01,
        FB_REMOTE1 = 2'b10
    } fb_e;

    typedef enum logic [3:0] {
        SRC_OFF = 4'b0000,
        SRC_CTRL_SENSOR = 4'b0001,
        SRC_IMU_YAW = 4'b0010,
        SRC_IMU_PITCH = 4'b0011,
        SRC_IMU_ROLL = 4'b0100,
        SRC_CIMU_YAW = 4'b0101,
        SRC_CIMU_PITCH = 4'b0110,
        SRC_CIMU_ROLL = 4'b0111,
        SRC_IO_QUAD = 4'b1000,
        SRC_IO_PWM0 = 4'b1001,
        SRC_IO_PWM1 = 4'b1010,
        SRC_IO_PWM2 = 4'b1011,
        SRC_IO_PWM3 = 4'b1100
    } src_e;

    typedef enum logic [2:0] {
        FK_CTRL_STAT = 3'b000,
        FK_CTRL_IMU = 3'b001,
        FK_IMU = 3'b010,
        FK_IO_QUAD = 3'b011,
        FK_IO_PWM = 3'b100,
        FK_CTRL_LIM = 3'b101,
        FK_IO_LIM = 3'b110
    } fkind_e;

    typedef struct packed {
        logic hit;
        logic has_vel;
        logic [DATA_W-1:0] pos;
        logic [DATA_W-1:0] vel;
    } dec_s;

endpackage

// ### rtl/store_if.sv
`timescale 1ns/1ps
interface store_if;
    import los_pkg::*;
    logic [NUM_FILT-1:0] wr_en;
    logic [NUM_FILT-1:0] wr_vel_en;
    logic [NUM_FILT-1:0][DATA_W-1:0] wr_pos;
    logic [NUM_FILT-1:0][DATA_W-1:0] wr_vel;
    logic [IDX_W-1:0] rd_a_idx;
    logic [IDX_W-1:0] rd_b_idx;
    logic [2*DATA_W-1:0] rd_a_q;
    logic [2*DATA_W-1:0] rd_b_q;
    modport owner(output wr_en, wr_vel_en, wr_pos, wr_vel, rd_a_idx,
        rd_b_idx, input rd_a_q, rd_b_q);
    modport store(input wr_en, wr_vel_en, wr_pos, wr_vel, rd_a_idx,
        rd_b_idx, output rd_a_q, rd_b_q);
endinterface

// ### rtl/filter_store.sv
`timescale 1ns/1ps
module filter_store (
    input wire logic clk,
    input wire logic rst_n,
    store_if.store st
);
    import los_pkg::*;

    // ************************************************************
    // decoded value words, one {vel,pos} pair per filter
    // ************************************************************
    typedef struct packed {
        logic [NUM_FILT-1:0][2*DATA_W-1:0] mem;
        logic [2*DATA_W-1:0] a_q;
        logic [2*DATA_W-1:0] b_q;
    } store_s;

    store_s q_ff;
    store_s nxt_q;

    always_comb begin
        nxt_q = q_ff;
        for (int i = 0; i < NUM_FILT; i++) begin
            if (st.wr_en[i]) begin
                nxt_q.mem[i][DATA_W-1:0] = st.wr_pos[i];
            end
            // a frame without velocity leaves the old velocity word alone
            if (st.wr_vel_en[i]) begin
                nxt_q.mem[i][2*DATA_W-1:DATA_W] = st.wr_vel[i];
            end
        end
        nxt_q.a_q = q_ff.mem[st.rd_a_idx];
        nxt_q.b_q = q_ff.mem[st.rd_b_idx];
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q_ff <= '0;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign st.rd_a_q = q_ff.a_q;
    assign st.rd_b_q = q_ff.b_q;
endmodule

// ### test/can_node_model.sv
`timescale 1ns/1ps
module can_node_model (
    input wire logic clk,
    output logic frame_valid,
    output los_pkg::fkind_e frame_kind,
    output logic [los_pkg::ID_W-1:0] frame_id,
    output logic [los_pkg::FRAME_W-1:0] frame_data
);
    import los_pkg::*;
    initial begin
        frame_valid = 1'b0;
        frame_kind = FK_CTRL_STAT;
        frame_id = 6'h3f;
        frame_data = 64'h0;
    end
    // between frames the id and data lines show the inverse, so stale data never matches
    task automatic send(input fkind_e k, input logic [ID_W-1:0] id,
        input logic [FRAME_W-1:0] d);
        @(posedge clk);
        frame_valid <= 1'b1;
        frame_kind <= k;
        frame_id <= id;
        frame_data <= d;
        @(posedge clk);
        frame_valid <= 1'b0;
        frame_id <= ~id;
        frame_data <= ~d;
    endtask
endmodule

// ### test/remote_sensor_los_supervisor_bench.sv
`timescale 1ns/1ps
module remote_sensor_los_supervisor_bench;
    import los_pkg::*;
    localparam int LOS = 20;
    localparam logic [63:0] PAY = 64'h9abc_1234_5678_def0;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wr_data = 32'h0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [31:0] rd_data, sel_pos, sel_vel;
    logic frame_valid;
    fkind_e frame_kind;
    logic [5:0] frame_id;
    logic [63:0] frame_data;
    logic fwd_in = 1'b0;
    logic rev_in = 1'b1;
    logic [15:0] duty = 16'h1234;
    logic [15:0] motor;
    logic fwd_act, rev_act, loss_flt, lim_flt, irq;
    int errors = 0;
    int compares = 0;
    always #2.5 clk = ~clk;
    remote_sensor_los_supervisor #(.LOS_CYCLES(LOS))
    i_remote_sensor_los_supervisor (.clk(clk), .rst_n(rst_n), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .frame_valid(frame_valid), .frame_kind(frame_kind),
        .frame_id(frame_id), .frame_data(frame_data),
        .forward_limit_input(fwd_in), .reverse_limit_input(rev_in),
        .target_duty(duty), .local_pos(32'h0bad_f00d),
        .local_vel(32'h0000_0011), .motor_duty_out(motor),
        .fwd_limit_active(fwd_act), .rev_limit_active(rev_act),
        .signal_loss_fault(loss_flt), .limit_fault(lim_flt),
        .sel_pos(sel_pos), .sel_vel(sel_vel), .irq(irq));
    can_node_model i_can_node_model (.clk(clk), .frame_valid(frame_valid),
        .frame_kind(frame_kind), .frame_id(frame_id),
        .frame_data(frame_data));
    // ****************************************
    // access tasks
    // ****************************************
    task automatic results();
        if (errors == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(negedge clk);
        chk(rd_data, exp);
    endtask
    function automatic logic [31:0] exp_pos(input int s);
        int n;
        n = (s >= 9) ? s - 9 : (s >= 5) ? s - 5 : s - 2;
        if (s == 1 || s == 8) return PAY[31:0];
        return {{16{PAY[16*n+15]}}, PAY[16*n+:16]};
    endfunction
    function automatic fkind_e kind_of(input int s);
        if (s == 1) return FK_CTRL_STAT;
        if (s <= 4) return FK_IMU;
        if (s <= 7) return FK_CTRL_IMU;
        if (s == 8) return FK_IO_QUAD;
        return FK_IO_PWM;
    endfunction
    // ****************************************
    // sequence
    // ****************************************
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        chk_reg(REG_CTRL, 32'h0);
        chk_reg(REG_FILT1, 32'h0);
        wr(REG_STATE, 32'hff);
        chk_reg(REG_STATE, 32'h80);
        chk_reg(8'h30, 32'h0);
        for (int s = 1; s <= 12; s++) begin
            wr(8'(REG_FILT0 + 4 * (s % 2)), 32'h0700 | s);
            i_can_node_model.send(kind_of(s), 6'h07, PAY);
            i_can_node_model.send(kind_of(s), 6'h08, ~PAY);
            chk_reg(8'(REG_VAL0_POS + 8 * (s % 2)), exp_pos(s));
            if (s == 1) chk_reg(REG_VAL1_VEL, PAY[63:32]);
        end
        wr(REG_FB_SEL, 32'h1);
        chk_reg(REG_FB_SEL, 32'h1);
        tick(5);
        chk(sel_pos, exp_pos(12));
        chk(sel_vel, PAY[63:32]);
        wr(REG_FB_SEL, 32'h2);
        tick(5);
        chk(sel_pos, exp_pos(11));
        wr(REG_FB_SEL, 32'h0);
        tick(LOS + 8);
        chk(sel_pos, 32'h0bad_f00d);
        chk(sel_vel, 32'h0000_0011);
        chk(loss_flt, 1'b1);
        chk(irq, 1'b0);
        wr(REG_MASK, 32'h2);
        tick(1);
        chk(irq, 1'b1);
        chk(motor, duty);
        chk_reg(REG_STATE, 32'h8e);
        wr(REG_FILT0, 32'h0);
        wr(REG_FILT1, 32'h0);
        wr(REG_STATUS, 32'hf);
        tick(2);
        chk(irq, 1'b0);
        chk(loss_flt, 1'b0);
        wr(REG_LIM_SRC, 32'h0501);
        i_can_node_model.send(FK_CTRL_LIM, 6'h05, 64'h1);
        tick(3);
        chk({fwd_act, rev_act}, 2'b10);
        tick(LOS - 6);
        chk({loss_flt, lim_flt}, 2'b00);
        chk(motor, duty);
        tick(6);
        chk(motor, 16'h0);
        chk({loss_flt, lim_flt}, 2'b11);
        chk_reg(REG_STATUS, 32'h9);
        i_can_node_model.send(FK_CTRL_LIM, 6'h05, 64'h2);
        tick(3);
        chk({loss_flt, motor}, {1'b0, duty});
        chk({fwd_act, rev_act}, 2'b01);
        wr(REG_CTRL, 32'h1);
        tick(LOS + 8);
        chk({loss_flt, lim_flt}, 2'b10);
        chk(motor, duty);
        wr(REG_CTRL, 32'h0);
        duty <= 16'h0;
        tick(3);
        chk({loss_flt, lim_flt, motor}, 18'h20000);
        // io node as limit source: a controller limit frame must be ignored
        wr(REG_LIM_SRC, 32'h0502);
        i_can_node_model.send(FK_CTRL_LIM, 6'h05, 64'h3);
        tick(2);
        chk({fwd_act, rev_act, loss_flt}, 3'b011);
        i_can_node_model.send(FK_IO_LIM, 6'h05, 64'h3);
        tick(2);
        chk({fwd_act, rev_act, loss_flt}, 3'b110);
        results();
    end
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        results();
    end
endmodule
